// file: bench/ats_osc_model.sv
// watch-crystal stand-in that drives the oscillator input pin
`timescale 1ns/100ps
module ats_osc_model #(
   parameter int HALF = 8
) (
   input  wire logic clock,
   input  wire logic run,
   output logic      osc
);
   int cnt;
   initial osc = 1'b0;
   initial cnt = 0;
   // square wave of 2*HALF cycles, stands low while stopped
   always @(posedge clock) begin
      if (!run) begin
         cnt <= 0;
         osc <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         osc <= ~osc;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the asynchronous timer clocking block
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
   num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       sleep_req = 1'b0;
   logic       deep_sleep = 1'b0;
   logic       osc_in_pin;
   logic [7:0] reg_rdata;
   logic       cmp_pin;
   logic       osc_en;
   logic       port_disc;
   logic       timer_irq;
   logic       cpu_run;
   logic [7:0] v;
   logic       pin0;
   int         w;
   int         num_errors = 0;
   int         checks_done = 0;
   int         cycles = 0;
   // clock select code, wait cycles, lowest and highest count
   int rows [8][4] = '{'{0, 40, 0, 0}, '{1, 40, 38, 46}, '{2, 36, 4, 4},
      '{3, 144, 4, 4}, '{4, 288, 4, 4}, '{5, 576, 4, 4},
      '{6, 1152, 4, 4}, '{7, 4608, 4, 4}};

   always #2.5 clock = ~clock;

   ats_timer_sync dut (
      .clock               (clock),
      .sys_rst             (sys_rst),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .osc_in_pin          (osc_in_pin),
      .sleep_req           (sleep_req),
      .deep_sleep          (deep_sleep),
      .reg_rdata           (reg_rdata),
      .compare_output_pin  (cmp_pin),
      .osc_enable          (osc_en),
      .osc_port_disconnect (port_disc),
      .timer_irq           (timer_irq),
      .cpu_run             (cpu_run)
   );

   ats_osc_model #(.HALF(8)) xtal (
      .clock (clock),
      .run   (osc_en),
      .osc   (osc_in_pin)
   );

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
      @(posedge clock);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask

   // poll status until no transfer is pending, bounded
   task automatic settle();
      int i;
      v = 8'hff;
      for (i = 0; i < 40 && v[2:0] !== 3'h0; i++) rd(ats_pkg::ADDR_STATUS, v);
      `CHK(v[2:0], 3'h0)
   endtask

   initial begin
      idle(6);
      sys_rst <= 1'b0;
      @(posedge clock);
      `CHK({osc_en, port_disc, cmp_pin, timer_irq, cpu_run}, 5'h01)
      wr(ats_pkg::ADDR_STATUS, 8'hf7);
      rd(ats_pkg::ADDR_STATUS, v);
      `CHK(v, 8'h00)
      wr(3'h6, 8'hff);
      rd(3'h6, v);
      `CHK(v, 8'h00)
      // every clock select code, prescaler reset just before counting
      for (int r = 0; r < 8; r++) begin
         wr(ats_pkg::ADDR_CONTROL, 8'h00);
         wr(ats_pkg::ADDR_COUNT, 8'h00);
         wr(ats_pkg::ADDR_CONTROL, 8'(rows[r][0]));
         wr(ats_pkg::ADDR_SPECIAL, 8'h01);
         idle(rows[r][1]);
         rd(ats_pkg::ADDR_COUNT, v);
         `CHK((v >= rows[r][2]) && (v <= rows[r][3]), 1'b1)
      end
      rd(ats_pkg::ADDR_SPECIAL, v);
      `CHK(v, 8'h00)
      // switch to the oscillator with interrupts off
      wr(ats_pkg::ADDR_CONTROL, 8'h01);
      wr(ats_pkg::ADDR_STATUS, 8'h08);
      rd(ats_pkg::ADDR_STATUS, v);
      `CHK(v, 8'h08)
      `CHK({osc_en, port_disc}, 2'h3)
      wr(ats_pkg::ADDR_CONTROL, 8'h11);
      wr(ats_pkg::ADDR_COUNT, 8'h00);
      wr(ats_pkg::ADDR_COMPARE, 8'h10);
      rd(ats_pkg::ADDR_STATUS, v);
      `CHK(v, 8'h0f)
      settle();
      wr(ats_pkg::ADDR_FLAGS, 8'h03);
      pin0 = cmp_pin;
      wr(ats_pkg::ADDR_CONTROL, 8'h91);
      settle();
      w = 0;
      while (timer_irq !== 1'b1 && w < 600) begin
         idle(1);
         w++;
      end
      `CHK(timer_irq, 1'b1)
      `CHK(cmp_pin, ~pin0)
      rd(ats_pkg::ADDR_FLAGS, v);
      `CHK(v, 8'h02)
      wr(ats_pkg::ADDR_FLAGS, 8'h02);
      idle(2);
      `CHK(timer_irq, 1'b0)
      // write lands after exactly two oscillator rising edges
      @(posedge osc_in_pin);
      @(posedge clock);
      wr(ats_pkg::ADDR_COMPARE, 8'h20);
      rd(ats_pkg::ADDR_STATUS, v);
      `CHK(v[1], 1'b1)
      @(posedge osc_in_pin);
      rd(ats_pkg::ADDR_STATUS, v);
      `CHK(v[1], 1'b1)
      @(posedge osc_in_pin);
      idle(2);
      rd(ats_pkg::ADDR_STATUS, v);
      `CHK(v[1], 1'b0)
      rd(ats_pkg::ADDR_COMPARE, v);
      `CHK(v, 8'h20)
      // sleep twice, waiting one oscillator cycle before re-entering
      for (int k = 0; k < 2; k++) begin
         wr(ats_pkg::ADDR_CONTROL, 8'h91);
         settle();
         wr(ats_pkg::ADDR_FLAGS, 8'h03);
         sleep_req <= 1'b1;
         idle(2);
         `CHK(cpu_run, 1'b0)
         w = 0;
         while (timer_irq !== 1'b1 && w < 6000) begin
            idle(1);
            w++;
         end
         sleep_req <= 1'b0;
         w = 0;
         while (cpu_run !== 1'b1 && w < 40) begin
            idle(1);
            w++;
         end
         `CHK((w >= 4) && (w <= 24), 1'b1)
      end
      // count read after wake-up goes through a register write first
      wr(ats_pkg::ADDR_CONTROL, 8'h91);
      settle();
      rd(ats_pkg::ADDR_COUNT, v);
      `CHK((v > 8'h20) && (v < 8'h30), 1'b1)
      // deep sleep loses the timer registers
      wr(ats_pkg::ADDR_COMPARE, 8'h55);
      settle();
      sleep_req  <= 1'b1;
      deep_sleep <= 1'b1;
      idle(3);
      `CHK(osc_en, 1'b0)
      sleep_req <= 1'b0;
      idle(10);
      deep_sleep <= 1'b0;
      `CHK(cpu_run, 1'b1)
      rd(ats_pkg::ADDR_COMPARE, v);
      `CHK(v, 8'h00)
      rd(ats_pkg::ADDR_CONTROL, v);
      `CHK(v, 8'h00)
      summarize();
   end
endmodule

// file: design/ats_pkg.sv
// package: constants and types for the asynchronous timer clock block
package ats_pkg;
   // register indices on the plain register port
   localparam logic [2:0] ADDR_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_COUNT   = 3'h1;
   localparam logic [2:0] ADDR_COMPARE = 3'h2;
   localparam logic [2:0] ADDR_STATUS  = 3'h3;
   localparam logic [2:0] ADDR_SPECIAL = 3'h4;
   localparam logic [2:0] ADDR_FLAGS   = 3'h5;
   // holding register slots, also busy-flag positions in the status reg
   localparam int SLOT_CONTROL = 0;
   localparam int SLOT_COMPARE = 1;
   localparam int SLOT_COUNT   = 2;
   localparam int NUM_SLOTS    = 3;
   // field positions
   localparam int ASYNC_SEL_BIT  = 3;  // async_clock_select in status reg
   localparam int PRESC_RST_BIT  = 0;  // prescaler_reset_bit, special reg
   localparam int FLAG_CMP_BIT   = 1;
   localparam int FLAG_OVF_BIT   = 0;
   localparam int CTL_CMP_IE_BIT = 7;  // compare_irq_enable
   localparam int CTL_OVF_IE_BIT = 6;  // overflow_irq_enable
   localparam int CTL_COM_LSB    = 4;  // compare output action, 2 bits
   localparam int CTL_CS_LSB     = 0;  // clock_select_field, 3 bits
   // reset values
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST   = 8'h00;
   localparam logic [7:0] COMPARE_RST = 8'h00;
   // timing counts
   localparam int XFER_EDGES   = 2;  // oscillator rising edges per transfer
   localparam int FLAG_SYNC    = 3;  // processor cycles of flag sync
   localparam int HALT_CYCLES  = 4;  // processor halt after wake-up
   localparam int PRESC_WIDTH  = 10; // enough for divide by 1024
   // compare output actions
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   // power state of the surrounding processor
   typedef enum logic [3:0] {
      PWR_RUN   = 4'b0001,
      PWR_SLEEP = 4'b0010,
      PWR_WAKE  = 4'b0100,
      PWR_HALT  = 4'b1000
   } ats_pwr_e;

   // register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ats_req_s;

   // complete state of the block
   typedef struct packed {
      ats_pwr_e                        pwr;
      logic [2:0]                      halt_cnt;
      logic                            armed;
      logic                            async_sel;
      logic                            osc_prev;
      logic [7:0]                      control;
      logic [7:0]                      count;
      logic [7:0]                      compare;
      logic [7:0]                      shadow;
      logic [NUM_SLOTS-1:0]            pend;
      logic [NUM_SLOTS-1:0][1:0]       edges;
      logic [NUM_SLOTS-1:0][7:0]       hold;
      logic [PRESC_WIDTH-1:0]          presc;
      logic [FLAG_SYNC-2:0][1:0]       flag_pipe;
      logic [1:0]                      flags;
      logic [7:0]                      rdata;
      logic                            cmp_pin;
      logic                            osc_enable;
      logic                            port_disc;
      logic                            irq;
      logic                            cpu_run;
   } ats_state_s;
endpackage

// file: design/ats_timer_sync.sv
// asynchronous timer clocking: holding registers, prescaler, wake-up
// Function
// RULE1: software follows safe clock-source switch sequence
// RULE2: writes land after two oscillator rising edges
// RULE3: each register has own holding register
// RULE4: software waits for busy before rewriting
// RULE5: status shows per-register update-busy flags
// RULE6: compare suppressed while compare/count write pending
// RULE7: interrupt logic rearms after one oscillator cycle
// RULE8: processor clock above four times oscillator
// RULE9: oscillator runs except power-down and standby
// RULE10: deep sleep wake-up loses timer registers
// RULE11: software waits one second for oscillator
// RULE12: wake-up starts on next timer clock
// RULE13: processor halted four cycles after wake-up
// RULE14: count read via shadow updated per edge
// RULE15: software syncs before reading count after wake
// RULE16: flag sync takes three cycles plus tick
// RULE17: compare pin changes on timer clock
// RULE18: select bit picks oscillator, frees port pins
// RULE19: prescaler taps 1,8,32,64,128,256,1024 or stop
// RULE20: prescaler reset bit clears the prescaler
// RULE21: select bit is status bit three
// RULE22: clock select codes map stop, 1, 8..1024
// RULE23: busy set with write, read-only to software
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ats_timer_sync (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic       osc_in_pin,
   input  wire logic       sleep_req,
   input  wire logic       deep_sleep,
   output logic      [7:0] reg_rdata,
   output logic            compare_output_pin,
   output logic            osc_enable,
   output logic            osc_port_disconnect,
   output logic            timer_irq,
   output logic            cpu_run
);
   ats_pkg::ats_state_s s_q;
   ats_pkg::ats_state_s s_d;
   ats_pkg::ats_req_s   req;
   logic                osc_rise;
   logic                src_tick;
   logic                tick;
   logic [9:0]          mask;
   logic                cmp_evt;
   logic                ovf_evt;
   logic                wake_cond;
   logic [1:0]          evt;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // oscillator edge and the timer source tick
   assign osc_rise = osc_in_pin && !s_q.osc_prev;
   assign src_tick = s_q.async_sel ? osc_rise : 1'b1; // RULE18

   // prescaler tap for each clock select code
   always_comb begin
      unique case (s_q.control[ats_pkg::CTL_CS_LSB +: 3]) // RULE22 RULE19
         3'h0: mask = 10'h000;
         3'h1: mask = 10'h000;
         3'h2: mask = 10'h007;
         3'h3: mask = 10'h01f;
         3'h4: mask = 10'h03f;
         3'h5: mask = 10'h07f;
         3'h6: mask = 10'h0ff;
         3'h7: mask = 10'h3ff;
      endcase
   end
   assign tick = src_tick && (s_q.control[ats_pkg::CTL_CS_LSB +: 3] != 3'h0)
                 && ((s_q.presc & mask) == mask); // RULE19

   // timer events; compare blocked while compare or count transfer pends
   assign cmp_evt = tick && (s_q.count == s_q.compare)
                    && !s_q.pend[ats_pkg::SLOT_COMPARE]
                    && !s_q.pend[ats_pkg::SLOT_COUNT]; // RULE6
   assign ovf_evt = tick && (s_q.count == 8'hff);
   assign evt = {cmp_evt, ovf_evt};
   assign wake_cond = |(s_q.flags & {s_q.control[ats_pkg::CTL_CMP_IE_BIT],
                                     s_q.control[ats_pkg::CTL_OVF_IE_BIT]});

   // next state of the whole block
   always_comb begin
      logic xfer;
      logic cnt_load;
      int   slot;
      xfer = 1'b0;
      cnt_load = 1'b0;
      slot = 0;
      s_d = s_q;
      s_d.osc_prev = osc_in_pin;
      // holding registers, one per synchronised register
      for (int i = 0; i < ats_pkg::NUM_SLOTS; i++) begin // RULE3
         xfer = s_q.pend[i] && (!s_q.async_sel ||
                (osc_rise && s_q.edges[i] == 2'(ats_pkg::XFER_EDGES - 1)));
         if (xfer) begin // RULE2
            s_d.pend[i]  = 1'b0; // RULE5
            s_d.edges[i] = 2'h0;
            unique case (i)
               ats_pkg::SLOT_CONTROL: s_d.control = s_q.hold[i];
               ats_pkg::SLOT_COMPARE: s_d.compare = s_q.hold[i];
               default: begin
                  s_d.count = s_q.hold[i];
                  cnt_load  = 1'b1; // a landing count wins over the tick
               end
            endcase
         end else if (s_q.pend[i] && osc_rise) begin
            s_d.edges[i] = s_q.edges[i] + 2'h1;
         end
      end
      // counter advance, unless a count transfer overrides it
      if (tick && !cnt_load) begin
         s_d.count = s_q.count + 8'h01;
      end
      // prescaler runs on the source clock
      if (src_tick) begin
         s_d.presc = s_q.presc + 10'h001;
      end
      // compare output follows the timer tick directly
      if (cmp_evt) begin // RULE17
         unique case (s_q.control[ats_pkg::CTL_COM_LSB +: 2])
            ats_pkg::COM_OFF:    s_d.cmp_pin = s_q.cmp_pin;
            ats_pkg::COM_TOGGLE: s_d.cmp_pin = !s_q.cmp_pin;
            ats_pkg::COM_CLEAR:  s_d.cmp_pin = 1'b0;
            ats_pkg::COM_SET:    s_d.cmp_pin = 1'b1;
         endcase
      end
      // count shadow refreshed per oscillator edge when asynchronous
      if (!s_q.async_sel || osc_rise) begin // RULE14
         s_d.shadow = s_q.count;
      end
      // interrupt flag synchroniser, three processor cycles in async mode
      s_d.flag_pipe[0] = evt;
      s_d.flag_pipe[1] = s_q.flag_pipe[0];
      // register writes
      if (req.wr) begin
         unique case (req.addr)
            ats_pkg::ADDR_CONTROL, ats_pkg::ADDR_COMPARE,
            ats_pkg::ADDR_COUNT: begin
               // slot order follows the busy bits, not the address map
               if (req.addr == ats_pkg::ADDR_CONTROL) begin
                  slot = ats_pkg::SLOT_CONTROL;
               end else if (req.addr == ats_pkg::ADDR_COMPARE) begin
                  slot = ats_pkg::SLOT_COMPARE;
               end else begin
                  slot = ats_pkg::SLOT_COUNT;
               end
               s_d.hold[slot]  = req.wdata;
               s_d.pend[slot]  = 1'b1; // RULE23
               s_d.edges[slot] = 2'h0;
            end
            ats_pkg::ADDR_STATUS:
               s_d.async_sel = req.wdata[ats_pkg::ASYNC_SEL_BIT]; // RULE21
            ats_pkg::ADDR_SPECIAL:
               if (req.wdata[ats_pkg::PRESC_RST_BIT]) begin
                  s_d.presc = '0; // RULE20
               end
            ats_pkg::ADDR_FLAGS:
               s_d.flags = s_q.flags & ~req.wdata[1:0];
            default: ;
         endcase
      end
      // hardware set wins over a software clear
      s_d.flags = s_d.flags |
                  (s_q.async_sel ? s_q.flag_pipe[1] : evt); // RULE16
      // processor power sequencing
      if (osc_rise) begin
         s_d.armed = 1'b1; // RULE7
      end
      unique case (s_q.pwr)
         ats_pkg::PWR_RUN:
            if (sleep_req) begin
               s_d.pwr = ats_pkg::PWR_SLEEP;
            end
         ats_pkg::PWR_SLEEP:
            if (deep_sleep && !sleep_req) begin
               s_d.pwr = ats_pkg::PWR_HALT;
               s_d.control = ats_pkg::CONTROL_RST; // RULE10
               s_d.count   = ats_pkg::COUNT_RST;
               s_d.compare = ats_pkg::COMPARE_RST;
               s_d.pend    = '0;
            end else if (!deep_sleep && s_q.armed && wake_cond) begin
               s_d.pwr = ats_pkg::PWR_WAKE;
            end
         ats_pkg::PWR_WAKE:
            if (tick) begin // RULE12
               s_d.pwr = ats_pkg::PWR_HALT;
            end
         ats_pkg::PWR_HALT:
            if (s_q.halt_cnt == 3'(ats_pkg::HALT_CYCLES - 1)) begin // RULE13
               s_d.pwr = ats_pkg::PWR_RUN;
               s_d.armed = osc_rise;
            end
      endcase
      s_d.halt_cnt = (s_d.pwr == ats_pkg::PWR_HALT &&
                      s_q.pwr == ats_pkg::PWR_HALT) ?
                     s_q.halt_cnt + 3'h1 : 3'h0;
      // registered outputs
      s_d.cpu_run    = (s_d.pwr == ats_pkg::PWR_RUN);
      s_d.osc_enable = s_d.async_sel &&
                       !(s_d.pwr == ats_pkg::PWR_SLEEP && deep_sleep); // RULE9
      s_d.port_disc  = s_d.async_sel; // RULE18
      s_d.irq        = wake_cond;
      s_d.rdata      = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            ats_pkg::ADDR_CONTROL: s_d.rdata = s_q.control;
            ats_pkg::ADDR_COUNT:   s_d.rdata = s_q.shadow; // RULE14
            ats_pkg::ADDR_COMPARE: s_d.rdata = s_q.compare;
            ats_pkg::ADDR_STATUS:
               s_d.rdata = {4'h0, s_q.async_sel, s_q.pend}; // RULE5
            ats_pkg::ADDR_FLAGS:   s_d.rdata = {6'h00, s_q.flags};
            default:               s_d.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.pwr <= ats_pkg::PWR_RUN;
         s_q.cpu_run <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata           = s_q.rdata;
   assign compare_output_pin  = s_q.cmp_pin;
   assign osc_enable          = s_q.osc_enable;
   assign osc_port_disconnect = s_q.port_disc;
   assign timer_irq           = s_q.irq;
   assign cpu_run             = s_q.cpu_run;

   // checks on the block's own behaviour
   busy_set_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE23
      req.wr && req.addr == ats_pkg::ADDR_COMPARE |=>
         s_q.pend[ats_pkg::SLOT_COMPARE])
      else $error("compare busy flag not set by write");
   xfer_edge_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
      s_q.async_sel && $past(s_q.async_sel) && $fell(s_q.pend[0])
         |-> $past(osc_rise))
      else $error("control transfer without oscillator edge");
   no_match_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE6
      s_q.pend[ats_pkg::SLOT_COMPARE] |-> !cmp_evt)
      else $error("compare match while compare write pending");
   flag_sync_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      s_q.async_sel && cmp_evt ##1 s_q.async_sel [*2]
         |=> s_q.flags[ats_pkg::FLAG_CMP_BIT])
      else $error("compare flag not set three cycles after tick");
   halt_four_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE13
      $rose(s_q.pwr == ats_pkg::PWR_HALT) |->
         !cpu_run [*4] ##1 cpu_run)
      else $error("processor halt not four cycles");
   shadow_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
      s_q.async_sel && $past(s_q.async_sel) && $changed(s_q.shadow)
         |-> $past(osc_rise))
      else $error("count shadow changed without oscillator edge");
   osc_run_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE9
      s_q.pwr == ats_pkg::PWR_SLEEP && deep_sleep && $stable(deep_sleep)
         |-> !osc_enable)
      else $error("oscillator enabled in deep sleep");
   presc_rst_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE20
      req.wr && req.addr == ats_pkg::ADDR_SPECIAL &&
         req.wdata[ats_pkg::PRESC_RST_BIT] |=> s_q.presc == '0)
      else $error("prescaler not reset");
   disc_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE18
      req.wr && req.addr == ats_pkg::ADDR_STATUS |=>
         osc_port_disconnect == $past(req.wdata[ats_pkg::ASYNC_SEL_BIT]))
      else $error("port disconnect does not follow select bit");
   wake_tick_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE12
      s_q.pwr == ats_pkg::PWR_WAKE && !tick |=> s_q.pwr == ats_pkg::PWR_WAKE)
      else $error("wake-up left before timer tick");
   // overflow flag takes the same synchroniser path as the compare flag
   ovf_sync_a: assert property ( // RULE16
      @(posedge clock) disable iff (sys_rst)
      s_q.async_sel && ovf_evt ##1 s_q.async_sel [*2]
         |=> s_q.flags[ats_pkg::FLAG_OVF_BIT])
      else $error("overflow flag not set three cycles after tick");
   // toggle action must flip the pin on the match tick itself
   cmp_pin_a: assert property ( // RULE17
      @(posedge clock) disable iff (sys_rst)
      cmp_evt && s_q.control[ats_pkg::CTL_COM_LSB +: 2] == ats_pkg::COM_TOGGLE
         |=> compare_output_pin != $past(compare_output_pin))
      else $error("compare pin did not toggle on match");
   // stopped code freezes the counter outside sleep unless a count write lands
   stop_a: assert property ( // RULE22
      @(posedge clock) disable iff (sys_rst)
      s_q.control[ats_pkg::CTL_CS_LSB +: 3] == 3'h0 &&
         !s_q.pend[ats_pkg::SLOT_COUNT] && s_q.pwr != ats_pkg::PWR_SLEEP
         |=> $stable(s_q.count))
      else $error("counter moved while stopped");
   // oscillator only runs with the asynchronous source selected
   osc_off_a: assert property ( // RULE9
      @(posedge clock) disable iff (sys_rst)
      !s_q.async_sel |-> !osc_enable)
      else $error("oscillator enabled in synchronous mode");

   // cover points for the main scenarios

   xfer_c: cover property (@(posedge clock) disable iff (sys_rst)
      s_q.async_sel && $fell(s_q.pend[ats_pkg::SLOT_COUNT]));
   wake_c: cover property (@(posedge clock) disable iff (sys_rst)
      s_q.pwr == ats_pkg::PWR_WAKE ##1 s_q.pwr == ats_pkg::PWR_HALT);
   match_c: cover property (@(posedge clock) disable iff (sys_rst)
      cmp_evt && s_q.async_sel);
   ovf_c: cover property (@(posedge clock) disable iff (sys_rst)
      ovf_evt && s_q.async_sel);
endmodule
